/* File: pkg/rsp_pkg.sv */
// ****************************************************************
// serial read output path constants
// ****************************************************************
package rsp_pkg;

    localparam int          REG_COUNT     = 32;
    localparam int          BYTE_W        = 8;

    // address/command byte fields
    localparam int          CMD_RD_BIT    = 7;
    localparam logic [4:0]  CLK_BURST_IDX = 5'h1F;
    localparam logic [7:0]  FTS_OFS       = 8'h17;
    localparam logic [4:0]  SEC_OFS       = 5'h00;

    // counts
    localparam logic [3:0]  CMD_BITS      = 4'h8;
    localparam logic [2:0]  BYTE_LAST     = 3'h7;
    localparam logic [4:0]  CLK_BURST_MSK = 5'h07;

    // power-on values
    localparam logic [7:0]  SEC_POR       = 8'h00;
    localparam logic [REG_COUNT*BYTE_W-1:0] REGS_POR = {REG_COUNT*BYTE_W{1'b0}};
    localparam logic        CS_N_RST      = 1'b1;
    localparam logic        SCLK_RST      = 1'b0;
    localparam logic        DIN_RST       = 1'b0;

    typedef enum logic [3:0] {
        RSP_IDLE  = 4'b0001,
        RSP_CMD   = 4'b0010,
        RSP_RDATA = 4'b0100,
        RSP_SKIP  = 4'b1000
    } rsp_state_t;

endpackage

/* File: rtl/rsp_sync.sv */
`timescale 1ns/1ns
// ****************************************************************
// two-stage synchroniser for the serial pins
// ****************************************************************
module rsp_sync #(
    parameter int              W   = 1,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic          sys_clk, // system clock
    input  wire logic          resetn,  // async reset, active low
    input  wire logic [W-1:0]  async_i, // pins from the master
    output logic      [W-1:0]  sync_o   // synchronised copy
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rsp_sync_t;

    rsp_sync_t st_reg;
    rsp_sync_t st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next.s1 = async_i;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg.s1 <= RST;
            st_reg.s2 <= RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_o = st_reg.s2;
endmodule

/* File: rtl/rsp_top.sv */
`timescale 1ns/1ns
// Behaviour
// - command bits are sampled from serial input on rising serial-clock edges.
// - after eighth falling edge of a read command, drive data, changing on falls.
// - each read byte goes out most significant bit first.
// - extra clocks with select low keep streaming further bytes; select high ends.
// - all registers forced to defaults during power-on reset, released after.
// - seconds register is zero after power-on; the bench checks it reads back zero.
// - serial output stays high impedance unless command is a read in data phase.
// - transfers start with select low; select high floats output, ends transfer.
module rsp_top
    import rsp_pkg::*;
(
    input  wire logic          sys_clk,    // 20 MHz system clock
    input  wire logic          resetn,     // power-on reset, active low
    input  wire logic          sclk,       // serial clock pin
    input  wire logic          cs_n,       // select pin, active low
    input  wire logic          din,        // serial data in pin
    output logic               dout,       // serial data out value
    output logic               dout_oe,    // high while dout is driven
    input  wire logic          upd_valid,  // register image update strobe
    input  wire logic [4:0]    upd_addr,   // register index to update
    input  wire logic [7:0]    upd_data,   // new register value
    output logic               fts_hit     // factory-test slot was written
);
    import rsp_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        rsp_state_t                    state;
        logic [7:0]                    cmd;
        logic [3:0]                    bit_cnt;
        logic [2:0]                    out_cnt;
        logic [7:0]                    shreg;
        logic [4:0]                    idx;
        logic                          burst;
        logic                          dout;
        logic                          sclk_q;
        logic                          fts_hit;
        logic [REG_COUNT-1:0][7:0]     regs;
    } rsp_top_t;

    rsp_top_t st_reg;
    rsp_top_t st_next;

    logic [2:0] pins_s;
    logic       s_sclk;
    logic       s_cs_n;
    logic       s_din;
    logic       sclk_rise;
    logic       sclk_fall;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    rsp_sync #(
        .W   (3),
        .RST ({CS_N_RST, SCLK_RST, DIN_RST})
    ) u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .async_i ({cs_n, sclk, din}),
        .sync_o  (pins_s)
    );

    assign s_cs_n    = pins_s[2];
    assign s_sclk    = pins_s[1];
    assign s_din     = pins_s[0];
    assign sclk_rise = s_sclk & ~st_reg.sclk_q;
    assign sclk_fall = ~s_sclk & st_reg.sclk_q;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] fetch(input logic [REG_COUNT-1:0][7:0] r, input logic [4:0] i);
        fetch = r[i];
    endfunction

    // clock burst wraps over the eight timekeeping bytes
    function automatic logic [4:0] step(input logic [4:0] i, input logic b);
        logic [4:0] n;
        n = i + 5'h01;
        step = b ? (n & CLK_BURST_MSK) : n;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next        = st_reg;
        st_next.sclk_q = s_sclk;
        if (upd_valid) begin
            st_next.regs[upd_addr] = upd_data;
        end
        if (s_cs_n) begin
            st_next.state   = RSP_IDLE;
            st_next.bit_cnt = 4'h0;
            st_next.out_cnt = 3'h0;
            st_next.cmd     = 8'h00;
            st_next.burst   = 1'b0;
            st_next.dout    = 1'b0;
        end else begin
            case (st_reg.state)
                RSP_IDLE, RSP_CMD: begin
                    st_next.state = RSP_CMD;
                    if (sclk_rise && st_reg.bit_cnt != CMD_BITS) begin
                        st_next.cmd     = {st_reg.cmd[6:0], s_din};
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    end else if (sclk_fall && st_reg.bit_cnt == CMD_BITS) begin
                        if (st_reg.cmd[CMD_RD_BIT]) begin
                            // first data bit leaves on the eighth falling edge
                            st_next.state   = RSP_RDATA;
                            st_next.burst   = (st_reg.cmd[4:0] == CLK_BURST_IDX);
                            st_next.idx     = (st_reg.cmd[4:0] == CLK_BURST_IDX) ? SEC_OFS
                                                                                 : st_reg.cmd[4:0];
                            st_next.shreg   = fetch(st_reg.regs, st_next.idx);
                            st_next.dout    = st_next.shreg[7];
                            st_next.out_cnt = 3'h0;
                        end else begin
                            // write data belongs to another path; output stays off
                            st_next.state = RSP_SKIP;
                            if (st_reg.cmd == FTS_OFS) begin
                                st_next.fts_hit = 1'b1;
                            end
                        end
                    end
                end
                RSP_RDATA: begin
                    if (sclk_fall) begin
                        if (st_reg.out_cnt == BYTE_LAST) begin
                            st_next.idx     = step(st_reg.idx, st_reg.burst);
                            st_next.shreg   = fetch(st_reg.regs, st_next.idx);
                            st_next.out_cnt = 3'h0;
                        end else begin
                            st_next.shreg   = {st_reg.shreg[6:0], 1'b0};
                            st_next.out_cnt = st_reg.out_cnt + 3'h1;
                        end
                        st_next.dout = st_next.shreg[7];
                    end
                end
                RSP_SKIP: begin
                    st_next.state = RSP_SKIP;
                end
                default: begin
                    st_next.state = RSP_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg.state    <= RSP_IDLE;
            st_reg.cmd      <= 8'h00;
            st_reg.bit_cnt  <= 4'h0;
            st_reg.out_cnt  <= 3'h0;
            st_reg.shreg    <= 8'h00;
            st_reg.idx      <= 5'h00;
            st_reg.burst    <= 1'b0;
            st_reg.dout     <= 1'b0;
            st_reg.sclk_q   <= SCLK_RST;
            // only power-on clears the factory-test mark
            st_reg.fts_hit  <= 1'b0;
            st_reg.regs     <= REGS_POR;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout    = st_reg.dout;
    assign dout_oe = (st_reg.state == RSP_RDATA);
    assign fts_hit = st_reg.fts_hit;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence cmd_done_rd;
        st_reg.state == RSP_CMD && !s_cs_n && sclk_fall && st_reg.bit_cnt == CMD_BITS && st_reg.cmd[CMD_RD_BIT];
    endsequence

    sequence mid_byte_fall;
        st_reg.state == RSP_RDATA && !s_cs_n && sclk_fall && st_reg.out_cnt != BYTE_LAST;
    endsequence

    chk_cmd_sample: assert property ((st_reg.state == RSP_CMD && !s_cs_n && sclk_rise
        && st_reg.bit_cnt != CMD_BITS) |=> st_reg.cmd[0] == $past(s_din))
        else $error("command bit not sampled on rising edge");

    chk_data_start: assert property (cmd_done_rd |=> dout_oe && st_reg.out_cnt == 3'h0)
        else $error("read data did not start after eighth falling edge");

    chk_msb_first: assert property (mid_byte_fall |=> st_reg.dout == $past(st_reg.shreg[6]))
        else $error("read data not shifted msb first");

    chk_burst_next: assert property ((st_reg.state == RSP_RDATA && !s_cs_n && sclk_fall
        && st_reg.out_cnt == BYTE_LAST) |=> dout_oe && st_reg.idx == step($past(st_reg.idx), st_reg.burst))
        else $error("burst read did not advance to next byte");

    chk_por_seconds: assert property ($rose(resetn) |-> st_reg.regs[SEC_OFS] == SEC_POR)
        else $error("seconds not zero after power-on");

    chk_hiz_write: assert property (dout_oe |-> st_reg.cmd[CMD_RD_BIT] && st_reg.bit_cnt == CMD_BITS)
        else $error("output driven without read command");

    chk_cs_high: assert property (s_cs_n |=> !dout_oe ##1 !dout_oe)
        else $error("output driven with select high");

    chk_cs_clear: assert property (s_cs_n |=> st_reg.bit_cnt == 4'h0 && st_reg.cmd == 8'h00)
        else $error("command state not cleared by select high");

    chk_fts_sticky: assert property (st_reg.fts_hit |=> st_reg.fts_hit)
        else $error("factory-test mark lost without power-on");
endmodule

/* File: testbench/rsp_master.sv */
`timescale 1ns/1ns
// ****************************************************************
// serial bus master model
// ****************************************************************
module rsp_master (
    input  wire logic sys_clk, // system clock
    output logic      sclk,    // serial clock, idle low
    output logic      cs_n,    // select, active low
    output logic      din,     // data towards the device
    input  wire logic dout,    // device data value
    input  wire logic dout_oe  // device drive enable
);
    logic [7:0] rx_q[$];
    logic       oe_bad    = 1'b0;
    logic       cmd_phase = 1'b0;
    logic       line;

    // weak pull-up on our input, so a floating pin reads one
    assign line = dout_oe ? dout : 1'b1;

    initial begin
        sclk      = 1'b0;
        cs_n      = 1'b1;
        din       = 1'b0;
    end

    always @(posedge sys_clk) begin
        if (dout_oe === 1'b1 && cmd_phase) begin
            oe_bad <= 1'b1;
        end
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // command byte first, then nbits data clocks; 400 ns link period
    task automatic xfer(input logic [7:0] cmd, input int nbits);
        logic [7:0] sh;
        int         i;
        rx_q.delete();
        sh = 8'h00;
        @(negedge sys_clk);
        cs_n      = 1'b0;
        cmd_phase = 1'b1;
        wait_n(4);
        for (i = 0; i < 8 + nbits; i++) begin
            din = (i < 8) ? cmd[7 - i] : ~din;
            wait_n(4);
            sclk = 1'b1;
            if (i >= 8) begin
                sh = {sh[6:0], line};
                if (i % 8 == 7) begin
                    rx_q.push_back(sh);
                end
            end
            wait_n(4);
            sclk = 1'b0;
            if (i == 7) begin
                cmd_phase = 1'b0;
            end
        end
        wait_n(4);
        cs_n = 1'b1;
        din  = ~din;
        wait_n(8);
    endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
// ****************************************************************
// read output path bench
// ****************************************************************
module testbench;
    import rsp_pkg::*;
    logic       sys_clk;
    logic       resetn;
    logic       sclk;
    logic       cs_n;
    logic       din;
    logic       dout;
    logic       dout_oe;
    logic       upd_valid;
    logic [4:0] upd_addr;
    logic [7:0] upd_data;
    logic       fts_hit;
    logic [7:0] img [32];
    int         failures;
    int         check_count;
    int         cycles;

    rsp_top uut (.sys_clk(sys_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .upd_valid(upd_valid), .upd_addr(upd_addr),
        .upd_data(upd_data), .fts_hit(fts_hit));
    rsp_master mst (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // whole run needs about 7300 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        foreach (img[i]) img[i] = REGS_POR[i*8 +: 8];
    endtask

    task automatic upd(input logic [4:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        upd_valid = 1'b1;
        upd_addr  = a;
        upd_data  = d;
        @(negedge sys_clk);
        upd_valid = 1'b0;
        img[a]    = d;
    endtask

    // read nb bytes; clock burst index wraps over eight
    task automatic rd_chk(input logic [7:0] cmd, input int nb, input logic [4:0] first);
        logic [4:0] idx;
        int         k;
        idx = first;
        mst.xfer(cmd, nb * 8);
        `CHK(mst.rx_q.size(), nb)
        for (k = 0; k < nb; k++) begin
            `CHK(mst.rx_q[k], img[idx])
            idx = (cmd[4:0] == CLK_BURST_IDX) ? ((idx + 5'h01) & CLK_BURST_MSK) : idx + 5'h01;
        end
        `CHK(dout_oe, 1'b0)
    endtask

    initial begin
        resetn    = 1'b0;
        upd_valid = 1'b0;
        upd_addr  = 5'h00;
        upd_data  = 8'h00;
        do_reset();
        rd_chk(8'h80, 1, SEC_OFS);
        rd_chk(8'h9F, 8, 5'h00);
        for (int i = 0; i < 32; i++) upd(i[4:0], 8'(i * 11) ^ 8'h3C);
        for (int i = 0; i < 31; i++) rd_chk({3'b100, i[4:0]}, 1, i[4:0]);
        rd_chk(8'h9E, 4, 5'h1E);
        rd_chk(8'h9F, 9, 5'h00);
        mst.xfer(8'h81, 3);
        rd_chk(8'h82, 2, 5'h02);
        mst.xfer(8'h05, 16);
        `CHK(mst.rx_q[0], 8'hFF)
        `CHK(mst.rx_q[1], 8'hFF)
        `CHK(fts_hit, 1'b0)
        mst.xfer(FTS_OFS, 8);
        `CHK(fts_hit, 1'b1)
        `CHK(mst.oe_bad, 1'b0)
        do_reset();
        `CHK(fts_hit, 1'b0)
        rd_chk(8'h83, 1, 5'h03);
        rd_chk(8'h80, 1, SEC_OFS);
        end_of_test();
    end
endmodule
